// File: timer_waveform_mode_control.sv
// timer waveform mode control with avalon register slave
//
// Register access over Avalon-MM was left to the implementer.
`timescale 1ns/100ps
module timer_waveform_mode_control (
  input wire logic clock,
  input wire logic rst,
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic timer_tick,
  output logic timer1_compare_out_a,
  output logic timer1_compare_out_b,
  output logic pin_override_a,
  output logic pin_override_b,
  output logic irq
);
  import timer_wave_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [7:0] ctrl_a; // output actions and low mode bits
  logic [1:0] mode_hi; // high mode bits
  logic [15:0] buf_a; // compare a as written
  logic [15:0] buf_b; // compare b as written
  logic [15:0] cmp_a; // compare a in use
  logic [15:0] cmp_b; // compare b in use
  logic [15:0] capture; // capture value, software loaded
  logic [15:0] cnt; // counter value
  dir_t dir; // counting direction
  dir_t next_dir;
  logic [ST_WIDTH-1:0] status; // sticky events
  logic [ST_WIDTH-1:0] mask; // interrupt enables
  logic ack; // second cycle of a bus access

  // ---------------------------------------------------------------
  // avalon decode
  // ---------------------------------------------------------------
  wire sel = read | write;
  wire wr_ok = write & ack; // write lands on the answering edge
  wire rd_ok = read & ~ack; // read data captured on the first edge
  wire hit_ctrl_a = address == ADDR_CTRL_A;
  wire hit_ctrl_b = address == ADDR_CTRL_B;
  wire hit_cmp_a = address == ADDR_CMP_A;
  wire hit_cmp_b = address == ADDR_CMP_B;
  wire hit_cap = address == ADDR_CAPTURE;
  wire hit_cnt = address == ADDR_COUNTER;
  wire hit_status = address == ADDR_STATUS;
  wire hit_mask = address == ADDR_MASK;
  // one wait state on every access
  assign waitrequest = sel & ~ack;

  // read mux, unmapped reads give zero
  wire [31:0] rd_mux =
    hit_ctrl_a ? {24'h000000, ctrl_a} :
    hit_ctrl_b ? {27'h0000000, mode_hi, 3'h0} :
    hit_cmp_a ? {16'h0000, buf_a} :
    hit_cmp_b ? {16'h0000, buf_b} :
    hit_cap ? {16'h0000, capture} :
    hit_cnt ? {16'h0000, cnt} :
    hit_status ? {29'h00000000, status} :
    hit_mask ? {29'h00000000, mask} :
    32'h00000000;

  // ---------------------------------------------------------------
  // mode decode
  // ---------------------------------------------------------------
  // reserved mode thirteen falls through to normal counting
  wire [3:0] mode = {mode_hi, ctrl_a[WGM_LO_LSB+1:WGM_LO_LSB]};
  mode_info_t info;
  assign info = mode_decode(mode);
  wire is_dual = info.fam == FAM_PC || info.fam == FAM_PFC;
  wire is_fast = info.fam == FAM_FAST;
  // top from fixed value, compare a or capture
  wire [15:0] top = mode_top(mode, cmp_a, capture);
  wire at_top = cnt == top;
  wire at_bot = cnt == BOTTOM;

  // ---------------------------------------------------------------
  // counter sequencing
  // ---------------------------------------------------------------
  // direction only reverses in the dual slope modes
  always_comb begin
    case (dir)
      DIR_UP: next_dir = (is_dual && at_top) ? DIR_DOWN : DIR_UP;
      DIR_DOWN: next_dir = (!is_dual || at_bot) ? DIR_UP : DIR_DOWN;
      default: next_dir = DIR_UP;
    endcase
  end

  // single slope wraps at top, dual slope steps along direction
  wire [15:0] next_cnt = (!is_dual && at_top) ? BOTTOM :
    (next_dir == DIR_DOWN ? cnt - STEP : cnt + STEP);
  // fast pwm passes through bottom on the wrap tick
  wire wrap = timer_tick & is_fast & at_top;

  // ---------------------------------------------------------------
  // event points
  // ---------------------------------------------------------------
  wire ovf_ev = timer_tick & (info.ovf == OVF_MAX ? cnt == TOP_MAX :
    (info.ovf == OVF_TOP ? at_top : at_bot));
  wire upd_ev = (info.upd == UPD_IMM) |
    (info.upd == UPD_TOP & timer_tick & at_top) |
    (info.upd == UPD_BOT & (is_dual ? timer_tick & at_bot : wrap));
  wire match_a = timer_tick & cnt == cmp_a;
  wire match_b = timer_tick & cnt == cmp_b;
  // toggle on channel a only in the compare-a-as-top pwm modes and in fast pwm with capture as top
  wire toggle_a_ok = mode == MODE_FP_CAP || mode == MODE_FP_CMP ||
    mode == MODE_PFC_CMP || mode == MODE_PC_CMP;

  // events gathered for the status register
  wire [ST_WIDTH-1:0] events = {match_b, match_a, ovf_ev};
  wire [ST_WIDTH-1:0] clr_bits = (wr_ok & hit_status) ? writedata[ST_WIDTH-1:0] : ST_RESET;
  // set wins over a clear in the same cycle
  wire [ST_WIDTH-1:0] next_status = (status & ~clr_bits) | events;

  // ---------------------------------------------------------------
  // output channels
  // ---------------------------------------------------------------
  logic [1:0] act [2];
  logic tok [2];
  chan_ev_t ev [2];
  logic ch_out [2];
  logic ch_ovr [2];

  assign act[0] = ctrl_a[ACT_A_LSB+1:ACT_A_LSB];
  assign act[1] = ctrl_a[ACT_B_LSB+1:ACT_B_LSB];
  // only channel a may toggle in a pwm mode
  assign tok[0] = toggle_a_ok;
  assign tok[1] = 1'b0;
  // per channel: match, direction, wrap, compare sitting on top
  assign ev[0] = '{match_a, dir == DIR_UP, wrap, cmp_a == top};
  assign ev[1] = '{match_b, dir == DIR_UP, wrap, cmp_b == top};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_chan
      compare_output_channel u_chan (
        .clock(clock),
        .rst(rst),
        .fam(info.fam),
        .action(act[gi]),
        .toggle_ok(tok[gi]),
        .ev(ev[gi]),
        .out(ch_out[gi]),
        .override(ch_ovr[gi])
      );
    end
  endgenerate

  assign timer1_compare_out_a = ch_out[0];
  assign timer1_compare_out_b = ch_out[1];
  assign pin_override_a = ch_ovr[0];
  assign pin_override_b = ch_ovr[1];
  // level interrupt while any unmasked event is pending
  assign irq = |(status & mask);

  // ---------------------------------------------------------------
  // bus handshake and read data
  // ---------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      ack <= 1'b0;
      readdata <= 32'h00000000;
    end else begin
      ack <= sel & ~ack;
      if (rd_ok) begin
        readdata <= rd_mux;
      end
    end
  end

  // ---------------------------------------------------------------
  // software registers
  // ---------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      ctrl_a <= CTRL_A_RESET;
      mode_hi <= WGM_HI_RESET;
      buf_a <= WORD_RESET;
      buf_b <= WORD_RESET;
      capture <= WORD_RESET;
      mask <= ST_RESET;
    end else if (wr_ok) begin
      // reserved bits 3:2 of control a stay zero
      if (hit_ctrl_a) begin
        ctrl_a <= writedata[7:0] & CTRL_A_WMASK;
      end
      if (hit_ctrl_b) begin
        mode_hi <= writedata[WGM_HI_LSB+1:WGM_HI_LSB];
      end
      if (hit_cmp_a) begin
        buf_a <= writedata[15:0];
      end
      if (hit_cmp_b) begin
        buf_b <= writedata[15:0];
      end
      if (hit_cap) begin
        capture <= writedata[15:0];
      end
      if (hit_mask) begin
        mask <= writedata[ST_WIDTH-1:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // counter, compare buffers and status
  // ---------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      cnt <= BOTTOM;
      dir <= DIR_UP;
      cmp_a <= WORD_RESET;
      cmp_b <= WORD_RESET;
      status <= ST_RESET;
    end else begin
      status <= next_status;
      if (timer_tick) begin
        cnt <= next_cnt;
        dir <= next_dir;
      end
      // buffered compare values move in at the update point
      if (upd_ev) begin
        cmp_a <= buf_a;
        cmp_b <= buf_b;
      end
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  // mode bits land from their own control registers
  a_mode_low_bits: assert property (wr_ok & hit_ctrl_a |=> mode[1:0] == $past(writedata[1:0]))
    else $error("low mode bits not taken from control a");
  a_mode_high_bits: assert property (wr_ok & hit_ctrl_b |=> mode[3:2] == $past(writedata[4:3]))
    else $error("high mode bits not taken from control b");
  // normal mode rolls over at max and flags it
  a_normal_max_flag: assert property (timer_tick & mode == 4'h0 & cnt == TOP_MAX
    |=> status[ST_OVF] && cnt == BOTTOM)
    else $error("normal mode wrap or flag at max missing");
  // dual slope turns at both ends
  a_pc8_reverse: assert property (timer_tick & mode == MODE_PC8 & dir == DIR_UP & cnt == TOP_8
    |=> dir == DIR_DOWN && cnt == 16'h00fe)
    else $error("phase correct 8-bit did not reverse at top");
  a_dual_bottom: assert property (timer_tick & is_dual & dir == DIR_DOWN & at_bot
    |=> dir == DIR_UP && cnt == STEP && status[ST_OVF])
    else $error("dual slope bottom turn or flag wrong");
  a_pfc_top_turn: assert property (timer_tick & info.fam == FAM_PFC & dir == DIR_UP & at_top
    |=> dir == DIR_DOWN)
    else $error("phase-frequency correct did not turn at top");
  // single slope wraps to bottom right after top
  a_fast_wrap_top: assert property (timer_tick & is_fast & at_top
    |=> cnt == BOTTOM && status[ST_OVF] && cmp_a == $past(buf_a))
    else $error("fast pwm wrap, flag or update wrong");
  a_ctc_wrap_top: assert property (timer_tick & mode == MODE_CTC_CMP & at_top |=> cnt == BOTTOM)
    else $error("clear on match did not wrap at compare a");
  // buffered compares move only at their update point
  a_pfc_update_bot: assert property (timer_tick & info.fam == FAM_PFC & at_bot
    |=> cmp_b == $past(buf_b))
    else $error("phase-frequency compare update at bottom missing");
  a_pc_hold_mid: assert property (timer_tick & info.fam == FAM_PC & ~at_top & ~hit_ctrl_a & ~hit_ctrl_b
    |=> cmp_a == $past(cmp_a))
    else $error("phase correct compare changed away from top");
  a_fast_hold_mid: assert property (is_fast & ~wrap |=> cmp_b == $past(cmp_b))
    else $error("fast pwm compare changed away from bottom");
  // the overflow flag stays until software clears it
  a_ovf_flag_sticky: assert property (status[ST_OVF] & ~(wr_ok & hit_status & writedata[ST_OVF])
    |=> status[ST_OVF])
    else $error("overflow flag dropped without a clear");
  // a write with a nonzero action takes the pin at once
  a_override_pins: assert property (wr_ok & hit_ctrl_a & writedata[7:6] != 2'h0 |=> pin_override_a)
    else $error("channel a pin not overridden");
  a_override_pin_b: assert property (wr_ok & hit_ctrl_a & writedata[5:4] != 2'h0 |=> pin_override_b)
    else $error("channel b pin not overridden");
endmodule

// File: timer_wave_pkg.sv
// constants, types and mode decoding shared by the timer waveform control
package timer_wave_pkg;

  // ---------------------------------------------------------------
  // register byte addresses
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL_A = 8'h80;
  localparam logic [7:0] ADDR_CTRL_B = 8'h84;
  localparam logic [7:0] ADDR_CMP_A = 8'h88;
  localparam logic [7:0] ADDR_CMP_B = 8'h8c;
  localparam logic [7:0] ADDR_CAPTURE = 8'h90;
  localparam logic [7:0] ADDR_COUNTER = 8'h94;
  localparam logic [7:0] ADDR_STATUS = 8'h98;
  localparam logic [7:0] ADDR_MASK = 8'h9c;

  // ---------------------------------------------------------------
  // field positions, write masks and reset values
  // ---------------------------------------------------------------
  localparam int ACT_A_LSB = 6;
  localparam int ACT_B_LSB = 4;
  localparam int WGM_LO_LSB = 0;
  localparam int WGM_HI_LSB = 3;
  localparam logic [7:0] CTRL_A_WMASK = 8'hf3;
  localparam logic [7:0] CTRL_A_RESET = 8'h00;
  localparam logic [1:0] WGM_HI_RESET = 2'h0;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam int ST_OVF = 0;
  localparam int ST_MATCH_A = 1;
  localparam int ST_MATCH_B = 2;
  localparam int ST_WIDTH = 3;
  localparam logic [2:0] ST_RESET = 3'h0;

  // ---------------------------------------------------------------
  // counter limits
  // ---------------------------------------------------------------
  localparam logic [15:0] TOP_MAX = 16'hffff;
  localparam logic [15:0] TOP_8 = 16'h00ff;
  localparam logic [15:0] TOP_9 = 16'h01ff;
  localparam logic [15:0] TOP_10 = 16'h03ff;
  localparam logic [15:0] BOTTOM = 16'h0000;
  localparam logic [15:0] STEP = 16'h0001;

  // ---------------------------------------------------------------
  // waveform mode numbers
  // ---------------------------------------------------------------
  localparam logic [3:0] MODE_PC8 = 4'h1;
  localparam logic [3:0] MODE_PC9 = 4'h2;
  localparam logic [3:0] MODE_PC10 = 4'h3;
  localparam logic [3:0] MODE_CTC_CMP = 4'h4;
  localparam logic [3:0] MODE_FP8 = 4'h5;
  localparam logic [3:0] MODE_FP9 = 4'h6;
  localparam logic [3:0] MODE_FP10 = 4'h7;
  localparam logic [3:0] MODE_PFC_CAP = 4'h8;
  localparam logic [3:0] MODE_PFC_CMP = 4'h9;
  localparam logic [3:0] MODE_PC_CAP = 4'ha;
  localparam logic [3:0] MODE_PC_CMP = 4'hb;
  localparam logic [3:0] MODE_CTC_CAP = 4'hc;
  localparam logic [3:0] MODE_FP_CAP = 4'he;
  localparam logic [3:0] MODE_FP_CMP = 4'hf;

  // ---------------------------------------------------------------
  // output actions and types
  // ---------------------------------------------------------------
  localparam logic [1:0] ACT_TOGGLE = 2'h1;
  localparam logic [1:0] ACT_CLEAR = 2'h2;
  localparam logic [1:0] ACT_SET = 2'h3;

  typedef enum logic [1:0] {FAM_NONPWM = 2'b00, FAM_FAST = 2'b01, FAM_PC = 2'b10, FAM_PFC = 2'b11} family_t;
  typedef enum logic [1:0] {UPD_IMM = 2'b00, UPD_TOP = 2'b01, UPD_BOT = 2'b10} update_t;
  typedef enum logic [1:0] {OVF_MAX = 2'b00, OVF_TOP = 2'b01, OVF_BOT = 2'b10} ovf_point_t;
  typedef enum logic {DIR_UP = 1'b0, DIR_DOWN = 1'b1} dir_t;

  typedef struct packed {
    family_t fam;
    update_t upd;
    ovf_point_t ovf;
  } mode_info_t;

  // per-channel events handed to an output channel
  typedef struct packed {
    logic match;
    logic up;
    logic wrap;
    logic cmp_top;
  } chan_ev_t;

  // mode number to family, update point and flag point
  function automatic mode_info_t mode_decode(input logic [3:0] m);
    mode_info_t r;
    r = '{FAM_NONPWM, UPD_IMM, OVF_MAX};
    case (m)
      MODE_PC8, MODE_PC9, MODE_PC10, MODE_PC_CAP, MODE_PC_CMP: r = '{FAM_PC, UPD_TOP, OVF_BOT};
      MODE_FP8, MODE_FP9, MODE_FP10, MODE_FP_CAP, MODE_FP_CMP: r = '{FAM_FAST, UPD_BOT, OVF_TOP};
      MODE_PFC_CAP, MODE_PFC_CMP: r = '{FAM_PFC, UPD_BOT, OVF_BOT};
      default: r = '{FAM_NONPWM, UPD_IMM, OVF_MAX};
    endcase
    return r;
  endfunction

  // mode number to counter top value
  function automatic logic [15:0] mode_top(input logic [3:0] m, input logic [15:0] cmp, input logic [15:0] cap);
    logic [15:0] t;
    t = TOP_MAX;
    case (m)
      MODE_PC8, MODE_FP8: t = TOP_8;
      MODE_PC9, MODE_FP9: t = TOP_9;
      MODE_PC10, MODE_FP10: t = TOP_10;
      MODE_CTC_CMP, MODE_PFC_CMP, MODE_PC_CMP, MODE_FP_CMP: t = cmp;
      MODE_CTC_CAP, MODE_PFC_CAP, MODE_PC_CAP, MODE_FP_CAP: t = cap;
      default: t = TOP_MAX;
    endcase
    return t;
  endfunction

endpackage

// File: compare_output_channel.sv
// one compare output channel: set, clear or toggle per mode family
`timescale 1ns/100ps
module compare_output_channel (
  input wire logic clock,
  input wire logic rst,
  input wire timer_wave_pkg::family_t fam,
  input wire logic [1:0] action,
  input wire logic toggle_ok,
  input wire timer_wave_pkg::chan_ev_t ev,
  output logic out,
  output logic override
);
  import timer_wave_pkg::*;

  // ---------------------------------------------------------------
  // action decode
  // ---------------------------------------------------------------
  wire is_pwm = fam != FAM_NONPWM;
  wire is_dual = fam == FAM_PC || fam == FAM_PFC;
  // match that may drive a fast pwm edge; ignored when compare sits on top
  wire fast_match = ev.match & ~ev.cmp_top;
  // high action bit: 10 non-inverting, 11 inverting
  wire inv = action == ACT_SET;
  wire pwm_act = action[1];
  wire tgl = ev.match & (action == ACT_TOGGLE) & (~is_pwm | toggle_ok);
  // non-pwm set and clear on match
  wire np_set = ~is_pwm & ev.match & (action == ACT_SET);
  wire np_clr = ~is_pwm & ev.match & (action == ACT_CLEAR);
  // fast pwm: match edge and bottom edge of opposite sense
  wire fp_on = fam == FAM_FAST & pwm_act;
  wire fp_set = fp_on & (inv ? fast_match : ev.wrap);
  wire fp_clr = fp_on & (inv ? ev.wrap : fast_match);
  // dual slope: sense flips with counting direction
  wire ds_on = is_dual & pwm_act & ev.match;
  wire ds_set = ds_on & (ev.up == inv);
  wire ds_clr = ds_on & (ev.up != inv);
  wire do_set = np_set | fp_set | ds_set;
  wire do_clr = np_clr | fp_clr | ds_clr;
  wire next_out = tgl ? ~out : (do_set ? 1'b1 : (do_clr ? 1'b0 : out));

  // any nonzero action takes the pin from the port logic
  assign override = |action;

  // ---------------------------------------------------------------
  // output flip-flop
  // ---------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      out <= 1'b0;
    end else begin
      out <= next_out;
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  a_nonpwm_set_high: assert property (~is_pwm & ev.match & action == ACT_SET |=> out)
    else $error("non-pwm set action did not drive high");
  a_fast_top_ignore: assert property (fam == FAM_FAST & pwm_act & ev.match & ev.cmp_top
    |=> out == !$past(action[0]))
    else $error("fast pwm match at top was not ignored");
  a_dual_clear_up: assert property (is_dual & action == ACT_CLEAR & ev.match & ev.up |=> !out)
    else $error("dual slope up match did not clear");
  a_pwm_toggle_off: assert property (is_pwm & ~toggle_ok & action == ACT_TOGGLE & ev.match
    |=> out == $past(out))
    else $error("toggle happened where channel is disconnected");
endmodule

// File: pin_port_model.sv
// far-side model: one port pin with a pull-up behind a compare output
`timescale 1ns/100ps
module pin_port_model (
  input wire logic dir,
  input wire logic port_val,
  input wire logic override,
  input wire logic wave,
  output logic pin
);
  // ---------------------------------------------------------------
  // pin level
  // ---------------------------------------------------------------
  // driver off leaves the pull-up; override picks the waveform
  assign pin = dir ? (override ? wave : port_val) : 1'b1;
endmodule

// File: tb_timer_waveform_mode_control.sv
// self-checking testbench for the timer waveform mode control
`timescale 1ns/100ps
module tb_timer_waveform_mode_control;
  import timer_wave_pkg::*;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic clock, rst, read, write, waitrequest, timer_tick, irq;
  logic [7:0] address;
  logic [31:0] writedata, readdata, q, r;
  logic out_a, out_b, ov_a, ov_b, dir_a, dir_b, port_a, port_b, pin_a, pin_b;
  int miscompares, num_checks, nt, n;
  int cyc = 0;
  // modes not covered by the hand-written scenarios
  logic [3:0] mode_list [9] = '{MODE_PC9, MODE_PC10, MODE_FP9, MODE_FP10, MODE_PFC_CMP, MODE_PC_CAP,
    MODE_PC_CMP, MODE_CTC_CAP, MODE_FP_CMP};

  timer_waveform_mode_control i_timer_waveform_mode_control (.clock(clock), .rst(rst), .address(address),
    .read(read), .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .timer_tick(timer_tick), .timer1_compare_out_a(out_a), .timer1_compare_out_b(out_b),
    .pin_override_a(ov_a), .pin_override_b(ov_b), .irq(irq));
  pin_port_model i_pin_a (.dir(dir_a), .port_val(port_a), .override(ov_a), .wave(out_a), .pin(pin_a));
  pin_port_model i_pin_b (.dir(dir_b), .port_val(port_b), .override(ov_b), .wave(out_b), .pin(pin_b));

  // 20 MHz clock
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic wrap_up;
    $display("checks %0d, mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // hang guard, far above the few thousand cycles the run needs
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      wrap_up;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      $display("CHECK FAILED at %0t: got %h, expected %h", $time, got, exp);
      miscompares++;
    end
  endtask

  // one avalon transfer, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    address <= a;
    writedata <= d;
    write <= w;
    read <= !w;
    // waitrequest sampled at each rising edge; only the hang guard ends a stuck wait
    do begin
      @(posedge clock);
    end while (waitrequest !== 1'b0);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clock);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    bus(1'b0, a, 32'h0);
  endtask

  // one timer tick, then time for status and pins to settle
  task automatic tick;
    timer_tick <= 1'b1;
    @(posedge clock);
    timer_tick <= 1'b0;
    repeat (2) @(posedge clock);
    nt++;
  endtask
  task automatic at(input int n);
    while (nt < n) tick;
  endtask

  task automatic do_reset;
    rst <= 1'b1;
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    repeat (2) @(posedge clock);
  endtask

  // compares land in mode 0 first, so active values equal the buffers
  task automatic setup(input logic [3:0] m, input logic [1:0] aa, input logic [1:0] ab,
                       input logic [15:0] ca, input logic [15:0] cb, input logic [15:0] cp);
    do_reset;
    wr(ADDR_CAPTURE, {16'h0, cp});
    wr(ADDR_CMP_A, {16'h0, ca});
    wr(ADDR_CMP_B, {16'h0, cb});
    wr(ADDR_CTRL_B, {27'h0, m[3:2], 3'h0});
    wr(ADDR_CTRL_A, {24'h0, aa, ab, 2'h0, m[1:0]});
    nt = 0;
  endtask

  // expected counter: single slope and dual slope
  function automatic int fast_cnt(input int n, input int top);
    return n % (top + 1);
  endfunction
  function automatic int dual_cnt(input int n, input int top);
    int p;
    p = n % (2 * top);
    return (p <= top) ? p : 2 * top - p;
  endfunction
  // expected counter per mode: compare a holds 9, capture holds 6
  function automatic int exp_cnt(input logic [3:0] m, input int ticks);
    int top;
    top = (m == MODE_PC9 || m == MODE_FP9) ? TOP_9 : (m == MODE_PC10 || m == MODE_FP10) ? TOP_10 :
      (m == MODE_PC_CAP || m == MODE_CTC_CAP) ? 6 : 9;
    if (m inside {MODE_FP9, MODE_FP10, MODE_CTC_CAP, MODE_FP_CMP}) begin
      return fast_cnt(ticks, top);
    end
    return dual_cnt(ticks, top);
  endfunction

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    rst = 1'b1;
    read = 1'b0;
    write = 1'b0;
    address = 8'h00;
    writedata = 32'h0;
    timer_tick = 1'b0;
    {dir_a, dir_b, port_a, port_b} = 4'h0;
    miscompares = 0;
    num_checks = 0;
    nt = 0;
    r = $urandom(32'h9aa9);
    do_reset;
    // reset values, masks, unmapped place
    rd(ADDR_CTRL_A);
    chk(q, 32'h0);
    rd(ADDR_CTRL_B);
    chk(q, 32'h0);
    r = $urandom;
    if ({r[4:3], r[1:0]} == 4'hd) r[3] = 1'b0;
    wr(ADDR_CTRL_A, r);
    rd(ADDR_CTRL_A);
    chk(q, r & 32'hf3);
    wr(ADDR_CTRL_B, r);
    rd(ADDR_CTRL_B);
    chk(q, r & 32'h18);
    wr(8'ha0, r);
    rd(8'ha0);
    chk(q, 32'h0);
    wr(ADDR_MASK, r);
    rd(ADDR_MASK);
    chk(q, r & 32'h7);
    // every action pair against the override and the pin
    do_reset;
    for (int v = 0; v < 16; v++) begin
      {dir_a, dir_b, port_a, port_b} <= 4'($urandom);
      wr(ADDR_CTRL_A, v << 4);
      chk(ov_a, v[3:2] != 0);
      chk(ov_b, v[1:0] != 0);
      chk(pin_a, dir_a ? ((v[3:2] != 0) ? 1'b0 : port_a) : 1'b1);
      chk(pin_b, dir_b ? ((v[1:0] != 0) ? 1'b0 : port_b) : 1'b1);
    end
    // clear on match, top from compare a, every action of channel b
    setup(4'h4, 2'h0, 2'h3, 16'h7, 16'h3, 16'h0);
    at(4);
    chk(out_b, 1);
    at(10);
    rd(ADDR_COUNTER);
    chk(q, fast_cnt(10, 7));
    rd(ADDR_STATUS);
    chk(q, 32'h6);
    wr(ADDR_CTRL_A, 32'h20);
    at(12);
    chk(out_b, 0);
    wr(ADDR_CTRL_A, 32'h10);
    at(20);
    chk(out_b, 1);
    at(28);
    chk(out_b, 0);
    // fast pwm 8 bit, a non-inverting, b inverting
    setup(4'h5, 2'h2, 2'h3, 16'h10, 16'h10, 16'h0);
    at(17);
    chk({out_a, out_b}, 2'b01);
    at(255);
    rd(ADDR_STATUS);
    chk(q[0], 0);
    at(256);
    chk({out_a, out_b}, 2'b10);
    rd(ADDR_STATUS);
    chk(q[0], 1);
    at(273);
    chk({out_a, out_b}, 2'b01);
    at(300);
    rd(ADDR_COUNTER);
    chk(q, fast_cnt(300, 255));
    // fast pwm, top from capture, toggle on a only
    setup(4'he, 2'h1, 2'h1, 16'h0, 16'h0, 16'h5);
    at(1);
    chk({out_a, out_b}, 2'b10);
    at(7);
    chk({out_a, out_b}, 2'b00);
    at(8);
    rd(ADDR_COUNTER);
    chk(q, fast_cnt(8, 5));
    // phase correct 8 bit, interrupt on overflow
    setup(4'h1, 2'h1, 2'h2, 16'h20, 16'h20, 16'h0);
    at(1);
    wr(ADDR_MASK, 32'h1);
    wr(ADDR_STATUS, 32'h7);
    at(300);
    rd(ADDR_COUNTER);
    chk(q, dual_cnt(300, 255));
    at(478);
    chk(out_b, 0);
    at(479);
    chk({out_a, out_b}, 2'b01);
    at(510);
    chk(irq, 0);
    rd(ADDR_STATUS);
    chk(q[0], 0);
    at(511);
    chk(irq, 1);
    rd(ADDR_STATUS);
    chk(q[0], 1);
    wr(ADDR_STATUS, 32'h1);
    chk(irq, 0);
    at(543);
    chk(out_b, 0);
    // phase and frequency correct, top from capture, inverting a
    setup(4'h8, 2'h3, 2'h0, 16'h10, 16'h0, 16'h40);
    at(1);
    wr(ADDR_STATUS, 32'h7);
    at(100);
    rd(ADDR_COUNTER);
    chk(q, dual_cnt(100, 64));
    at(112);
    chk(out_a, 1);
    at(113);
    chk(out_a, 0);
    at(128);
    rd(ADDR_STATUS);
    chk(q[0], 0);
    at(129);
    rd(ADDR_STATUS);
    chk(q[0], 1);
    // remaining modes, 9 and 10 bit tops and short compare or capture tops; in mode 15 compare a sits on top
    foreach (mode_list[i]) begin
      setup(mode_list[i], 2'h2, 2'h0, 16'h9, 16'h0, 16'h6);
      n = 10 + $urandom % 20;
      at(n);
      rd(ADDR_COUNTER);
      chk(q, exp_cnt(mode_list[i], n));
      if (mode_list[i] == MODE_FP_CMP) begin
        chk(out_a, 1);
      end
    end
    wrap_up;
  end
endmodule
